// ===== src/unit_select.sv
// unit selection and host character gating for a multidrop chain
`include "unit_select_defs.svh"

// What this block does
// - parse attention, two digits, cr lf
// - two-digit units 01..32, 00 broadcast
// - matching id switches enters active mode
// - pass commands only when active or listening
// - only unit id 1 sends ready banner
// - query suffix makes active unit echo id
// - 00 gives listen mode, command responses suppressed
// - individual select ends listen mode
// - keyword forms handled by downstream decoder
module unit_select (
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  ce_i,
    input  wire logic [5:0]            unit_id_i,
    input  wire unit_select_pkg::char_s rx_i,
    input  wire unit_select_pkg::char_s cmd_tx_i,
    input  wire logic                  tx_ready_i,
    output unit_select_pkg::char_s     cmd_o,
    output unit_select_pkg::char_s     tx_o,
    output logic                       active_o,
    output logic                       listen_o
);
    import unit_select_pkg::*;

    // parser, mode and transmit state
    parse_e     parse_reg;
    mode_e      mode_reg;
    logic [3:0] tens_reg;
    logic [6:0] num_reg;
    logic       query_reg;
    logic [2:0] banner_reg;
    logic       banner_pend_reg;
    logic [1:0] echo_reg;
    logic       is_digit;
    logic [3:0] digit;
    logic       sel_done;
    logic       num_ok;
    logic [3:0] id_tens;
    logic [3:0] id_ones;

    // character classes and selection strobe
    assign is_digit = rx_i.valid && rx_i.data >= `CH_ZERO && rx_i.data <= `CH_NINE;
    assign digit    = rx_i.data[3:0];
    assign sel_done = ce_i && rx_i.valid && parse_reg == P_LF && rx_i.data == `CH_LF;
    assign num_ok   = num_reg <= `UNIT_MAX;

    // decimal digits of the unit id for the echo, no divider needed
    always_comb begin
        if (unit_id_i >= 6'h1e) begin
            id_tens = 4'h3;
            id_ones = 4'(unit_id_i - 6'h1e);
        end else if (unit_id_i >= 6'h14) begin
            id_tens = 4'h2;
            id_ones = 4'(unit_id_i - 6'h14);
        end else if (unit_id_i >= 6'h0a) begin
            id_tens = 4'h1;
            id_ones = 4'(unit_id_i - 6'h0a);
        end else begin
            id_tens = 4'h0;
            id_ones = unit_id_i[3:0];
        end
    end

    // selection sequence parser
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            parse_reg <= P_IDLE;
        end else if (ce_i && rx_i.valid) begin
            unique case (parse_reg)
                P_IDLE, P_CMD: begin
                    if (rx_i.data == `CH_ATTN) begin
                        parse_reg <= P_TENS;
                    end else if (rx_i.data == `CH_CR || rx_i.data == `CH_LF) begin
                        parse_reg <= P_IDLE;
                    end else begin
                        parse_reg <= P_CMD;
                    end
                end
                P_TENS: begin
                    if (is_digit) begin
                        parse_reg <= P_ONES;
                    end else begin
                        parse_reg <= P_CMD;
                    end
                end
                P_ONES: begin
                    if (is_digit) begin
                        parse_reg <= P_TAIL;
                    end else begin
                        parse_reg <= P_CMD;
                    end
                end
                P_TAIL: begin
                    if (rx_i.data == `CH_QUERY && !query_reg) begin
                        parse_reg <= P_TAIL;
                    end else if (rx_i.data == `CH_CR) begin
                        parse_reg <= P_LF;
                    end else begin
                        parse_reg <= P_CMD;
                    end
                end
                P_LF: begin
                    parse_reg <= P_IDLE;
                end
            endcase
        end
    end

    // digit capture, seven bits so that 99 cannot wrap onto a valid id
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tens_reg  <= 4'h0;
            num_reg   <= 7'h00;
            query_reg <= 1'b0;
        end else if (ce_i && is_digit && parse_reg == P_TENS) begin
            tens_reg <= digit;
        end else if (ce_i && is_digit && parse_reg == P_ONES) begin
            num_reg   <= 7'(tens_reg * 7'h0a) + {3'h0, digit};
            query_reg <= 1'b0;
        end else if (ce_i && rx_i.valid && parse_reg == P_TAIL && rx_i.data == `CH_QUERY) begin
            query_reg <= 1'b1;
        end
    end

    // mode register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_reg <= M_IDLE;
        end else if (sel_done && num_ok) begin
            if (num_reg == `UNIT_BCAST) begin
                mode_reg <= M_LISTEN;
            end else if (num_reg == unit_id_i) begin
                mode_reg <= M_ACTIVE;
            end else begin
                mode_reg <= M_IDLE;
            end
        end
    end

    // commands pass to the keyword decoder only when selected
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cmd_o <= '0;
        end else if (ce_i) begin
            cmd_o.valid <= rx_i.valid && mode_reg != M_IDLE && parse_reg != P_TENS
                           && parse_reg != P_ONES && parse_reg != P_TAIL
                           && parse_reg != P_LF && rx_i.data != `CH_ATTN;
            cmd_o.data  <= rx_i.data;
        end
    end

    // ready banner after reset, id 1 only
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            banner_pend_reg <= 1'b1;
            banner_reg      <= 3'h0;
        end else if (ce_i) begin
            if (banner_pend_reg) begin
                banner_pend_reg <= 1'b0;
                banner_reg      <= (unit_id_i == `BANNER_ID) ? `BANNER_LEN : 3'h0;
            end else if (banner_reg != 3'h0 && tx_ready_i) begin
                banner_reg <= banner_reg - 3'h1;
            end
        end
    end

    // id echo request after a query select
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            echo_reg <= 2'h0;
        end else if (ce_i) begin
            if (sel_done && num_ok && query_reg && num_reg == unit_id_i
                && num_reg != `UNIT_BCAST) begin
                echo_reg <= 2'h2;
            end else if (echo_reg != 2'h0 && banner_reg == 3'h0 && tx_ready_i) begin
                echo_reg <= echo_reg - 2'h1;
            end
        end
    end

    // transmit mux: banner, then echo, then command responses
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_o <= '0;
        end else if (ce_i) begin
            tx_o.valid <= 1'b0;
            tx_o.data  <= 8'h00;
            if (tx_ready_i && banner_reg != 3'h0 && !banner_pend_reg) begin
                tx_o.valid <= 1'b1;
                unique case (banner_reg)
                    3'h4:    tx_o.data <= `CH_R;
                    3'h3:    tx_o.data <= `CH_D;
                    3'h2:    tx_o.data <= `CH_Y;
                    default: tx_o.data <= `CH_CR;
                endcase
            end else if (tx_ready_i && echo_reg != 2'h0) begin
                tx_o.valid <= 1'b1;
                tx_o.data  <= (echo_reg == 2'h2)
                              ? (`CH_ZERO + {4'h0, id_tens})
                              : (`CH_ZERO + {4'h0, id_ones});
            end else if (mode_reg == M_ACTIVE && tx_ready_i) begin
                tx_o <= cmd_tx_i;
            end
        end
    end

    // mode flags
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            active_o <= 1'b0;
            listen_o <= 1'b0;
        end else if (ce_i) begin
            active_o <= mode_reg == M_ACTIVE;
            listen_o <= mode_reg == M_LISTEN;
        end
    end
endmodule

// ===== common/unit_select_defs.svh
// timing-free constants for the unit select command interpreter
`ifndef UNIT_SELECT_DEFS_SVH
`define UNIT_SELECT_DEFS_SVH
`define CH_ATTN     8'h3c
`define CH_QUERY    8'h3f
`define CH_CR       8'h0d
`define CH_LF       8'h0a
`define CH_ZERO     8'h30
`define CH_NINE     8'h39
`define UNIT_MIN    6'h01
`define UNIT_MAX    6'h20
`define UNIT_BCAST  6'h00
`define BANNER_ID   6'h01
`define BANNER_LEN  3'h4
`define CH_R        8'h52
`define CH_D        8'h44
`define CH_Y        8'h59
`endif

// ===== common/unit_select_pkg.sv
// types for the unit select command interpreter
package unit_select_pkg;
    typedef enum logic [2:0] {
        P_IDLE  = 3'b000,
        P_TENS  = 3'b001,
        P_ONES  = 3'b011,
        P_TAIL  = 3'b010,
        P_LF    = 3'b110,
        P_CMD   = 3'b111
    } parse_e;
    typedef enum logic [1:0] {
        M_IDLE   = 2'b00,
        M_ACTIVE = 2'b01,
        M_LISTEN = 2'b11
    } mode_e;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } char_s;
endpackage

// ===== dv/unit_select_chk.sv
// port checker for the unit select interpreter
`include "unit_select_defs.svh"
module unit_select_chk (
    input wire logic                   clk_i,
    input wire logic                   reset_i,
    input wire logic [5:0]             unit_id_i,
    input wire unit_select_pkg::char_s rx_i,
    input wire unit_select_pkg::char_s cmd_o,
    input wire unit_select_pkg::char_s tx_o,
    input wire logic                   active_o,
    input wire logic                   listen_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // forwarding, gating, mode, transmit and banner checks
    property p_fwd; cmd_o.valid |-> $past(rx_i.valid) && cmd_o.data == $past(rx_i.data); endproperty
    property p_gate; cmd_o.valid |-> active_o || listen_o; endproperty
    property p_nosel; cmd_o.valid |-> cmd_o.data != `CH_ATTN; endproperty
    property p_excl; !(active_o && listen_o); endproperty
    property p_quiet; listen_o && $past(listen_o) |-> !tx_o.valid; endproperty
    property p_silent; $fell(reset_i) && unit_id_i != `BANNER_ID |-> !tx_o.valid [*8]; endproperty
    property p_banner;
        $fell(reset_i) && unit_id_i == `BANNER_ID |-> ##[1:3] tx_o.valid && tx_o.data == `CH_R;
    endproperty
    property p_cause;
        !$past(reset_i) && ($changed(active_o) || $changed(listen_o))
            |-> $past(rx_i.valid && rx_i.data == `CH_LF, 2);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forwarded char wrong");
    a_gate: assert property (p_gate) else $error("char forwarded while idle");
    a_nosel: assert property (p_nosel) else $error("attention char forwarded");
    a_excl: assert property (p_excl) else $error("active and listen together");
    a_quiet: assert property (p_quiet) else $error("transmit in listen mode");
    a_silent: assert property (p_silent) else $error("banner from wrong unit");
    a_banner: assert property (p_banner) else $error("banner missing");
    a_cause: assert property (p_cause) else $error("mode change without select");
    c_active: cover property ($rose(active_o));
    c_listen: cover property ($rose(listen_o));
    c_banner: cover property (tx_o.valid && tx_o.data == `CH_R);
endmodule

bind unit_select unit_select_chk chk (.clk_i(clk_i), .reset_i(reset_i), .unit_id_i(unit_id_i),
    .rx_i(rx_i), .cmd_o(cmd_o), .tx_o(tx_o), .active_o(active_o), .listen_o(listen_o));

// ===== dv/unit_select_host.sv
// host computer model sending lines onto the chain
module unit_select_host (
    input  wire logic              clk_i,
    output unit_select_pkg::char_s rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import unit_select_pkg::*;
    initial rx_o = '0;
    // one pulse per char, idle data inverted
    task send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk_i);
            rx_o <= '{valid: 1'b1, data: s[i]};
            @(posedge clk_i);
            rx_o <= '{valid: 1'b0, data: ~s[i]};
        end
        repeat (4) @(posedge clk_i);
    endtask
endmodule

// ===== dv/unit_select_bench.sv
// testbench for the unit select interpreter
`include "unit_select_defs.svh"
module unit_select_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import unit_select_pkg::*;
    logic       clk_i = 0, reset_i = 1, ce_i = 1, tx_ready_i = 1, active_o, listen_o;
    logic [5:0] unit_id_i = 6'h05;
    char_s      rx_i, cmd_o, tx_o;
    char_s      cmd_tx_i = '0;
    int         failures = 0, comparisons = 0, cycles = 0;
    logic [7:0] txq[$], cmdq[$];
    unit_select_host host (.clk_i(clk_i), .rx_o(rx_i));
    unit_select uut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .unit_id_i(unit_id_i),
        .rx_i(rx_i), .cmd_tx_i(cmd_tx_i), .tx_ready_i(tx_ready_i), .cmd_o(cmd_o),
        .tx_o(tx_o), .active_o(active_o), .listen_o(listen_o));
    initial forever #10 clk_i = ~clk_i;
    // capture outputs, cut a hang short
    always @(posedge clk_i) begin
        if (tx_o.valid === 1'b1) txq.push_back(tx_o.data);
        if (cmd_o.valid === 1'b1) cmdq.push_back(cmd_o.data);
        cycles++;
        if (cycles == 4000) begin
            failures++;
            complete_run();
        end
    end
    task check(input logic c, input string m);
        comparisons++;
        if (c !== 1'b1) begin
            failures++;
            $display("Error %0t %s", $time, m);
        end
    endtask
    task do_reset(input logic [5:0] id);
        reset_i <= 1'b1;
        unit_id_i <= id;
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask
    task pulse_tx;
        @(posedge clk_i);
        cmd_tx_i <= '{valid: 1'b1, data: 8'h41};
        @(posedge clk_i);
        cmd_tx_i <= '0;
        repeat (3) @(posedge clk_i);
    endtask
    task t_silent;
        do_reset(6'h05);
        check(txq.size() == 0, "silent");
    endtask
    task t_query;
        host.send("<05?\r\n");
        check(active_o === 1'b1 && {txq[0], txq[1]} === "05" && txq.size() == 2, "query");
        check(cmdq.size() == 0, "select forwarded");
    endtask
    task t_other;
        host.send("<07\r\nAB\r<69\r\n");
        check(active_o === 1'b0 && cmdq.size() == 0, "deselect");
        host.send("<05\r\n<33\r\n");
        check(active_o === 1'b1, "out of range");
    endtask
    task t_listen;
        txq.delete();
        cmdq.delete();
        host.send("<00\r\nGO\r");
        pulse_tx();
        check(listen_o === 1'b1 && cmdq.size() == 3 && cmdq[0] === 8'h47, "listen");
        check(txq.size() == 0, "listen transmit");
        check(cmdq[1] === 8'h4f && cmdq[2] === `CH_CR, "keyword chars");
        host.send("<05\r\n");
        pulse_tx();
        check(listen_o === 1'b0 && active_o === 1'b1 && txq[0] === 8'h41, "leave listen");
    endtask
    task t_banner;
        txq.delete();
        do_reset(`BANNER_ID);
        check({txq[0], txq[1], txq[2], txq[3]} === {`CH_R, `CH_D, `CH_Y, `CH_CR}, "banner");
    endtask
    task complete_run;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        t_silent();
        t_query();
        t_other();
        t_listen();
        t_banner();
        complete_run();
    end
endmodule
